// File: pkg/sat_regs.vh
// constants for the speculation address table: op codes, event kinds, sizes
`ifndef SAT_REGS_VH
`define SAT_REGS_VH

`define SAT_ENTRIES      8
`define SAT_IDX_W        3
`define SAT_PA_W         32
`define SAT_SIZE_W       5
`define SAT_REG_W        7
`define SAT_EPOCH_W      2
`define SAT_TAG_W        10
`define SAT_LINE_LSB     6
`define SAT_PAGE_LSB     12

`define SAT_OP_W         4
`define SAT_OP_ADV       4'h0
`define SAT_OP_SPEC_ADV  4'h1
`define SAT_OP_CHKLD_NC  4'h2
`define SAT_OP_CHKLD_CLR 4'h3
`define SAT_OP_CHKLD_ACQ 4'h4
`define SAT_OP_CHKA_CLR  4'h5
`define SAT_OP_CHKA_NC   4'h6
`define SAT_OP_INV_ALL   4'h7
`define SAT_OP_INV_ONE   4'h8

`define SAT_EV_W         3
`define SAT_EV_LSTORE    3'h0
`define SAT_EV_RSTORE    3'h1
`define SAT_EV_SEMA      3'h2
`define SAT_EV_PURGE     3'h3
`define SAT_EV_EVICT     3'h4
`define SAT_EV_SPILL     3'h5

`endif

// File: rtl/sat_tag_gen.v
// register tag builder: physical register number, type and stack epoch
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_tag_gen (
	input  wire [`SAT_REG_W-1:0]   reg_num,
	input  wire                    reg_fr,
	input  wire [`SAT_EPOCH_W-1:0] stack_epoch,
	output wire [`SAT_TAG_W-1:0]   reg_tag
);
	// epoch tells a spilled register instance from the live one, so stack
	// wraparound needs no table purge
	assign reg_tag = {stack_epoch, reg_fr, reg_num};
endmodule // sat_tag_gen

// File: rtl/sat_overlap.v
// compares one entry's memory region against an invalidation event
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_overlap (
	input  wire [`SAT_PA_W-1:0]   ent_addr,
	input  wire [`SAT_SIZE_W-1:0] ent_size,
	input  wire [`SAT_PA_W-1:0]   ev_addr,
	input  wire                   ev_page,
	output wire                   overlap
);
	wire [`SAT_PA_W-1:0] ent_last;
	wire                 line_hit;
	wire                 page_hit;

	assign ent_last = ent_addr + {{(`SAT_PA_W-`SAT_SIZE_W){1'b0}}, ent_size}
		- {{(`SAT_PA_W-1){1'b0}}, 1'b1};
	// line granularity over-invalidates small stores; cheap and allowed
	assign line_hit =
		(ent_addr[`SAT_PA_W-1:`SAT_LINE_LSB] ==
		 ev_addr[`SAT_PA_W-1:`SAT_LINE_LSB]) ||
		(ent_last[`SAT_PA_W-1:`SAT_LINE_LSB] ==
		 ev_addr[`SAT_PA_W-1:`SAT_LINE_LSB]);
	assign page_hit =
		(ent_addr[`SAT_PA_W-1:`SAT_PAGE_LSB] ==
		 ev_addr[`SAT_PA_W-1:`SAT_PAGE_LSB]) ||
		(ent_last[`SAT_PA_W-1:`SAT_PAGE_LSB] ==
		 ev_addr[`SAT_PA_W-1:`SAT_PAGE_LSB]);
	assign overlap = ev_page ? page_hit : line_hit;
endmodule // sat_overlap

// File: rtl/sat_table.v
// speculation address table: allocate, check and invalidate entries
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_table #(
	parameter FAIL_AS_FAULT     = 0,
	parameter HIT_RELOAD        = 0,
	parameter HIT_IGNORE_FAULTS = 1,
	parameter MISMATCH_FAULT    = 0
) (
	input  wire                    mclk,
	input  wire                    srst,
	input  wire                    legacy_mode,
	input  wire                    op_valid,
	input  wire [`SAT_OP_W-1:0]    op_code,
	input  wire [`SAT_REG_W-1:0]   op_reg_num,
	input  wire                    op_reg_fr,
	input  wire [`SAT_EPOCH_W-1:0] op_stack_epoch,
	input  wire [`SAT_PA_W-1:0]    op_paddr,
	input  wire [`SAT_SIZE_W-1:0]  op_size,
	input  wire                    op_deferred,
	input  wire                    op_base_upd,
	input  wire                    op_prefetch,
	input  wire                    op_fault_pending,
	input  wire                    ev_valid,
	input  wire [`SAT_EV_W-1:0]    ev_kind,
	input  wire [`SAT_PA_W-1:0]    ev_paddr,
	output reg                     res_valid_ff,
	output reg                     res_fall_through_ff,
	output reg                     res_branch_ff,
	output reg                     res_fault_ff,
	output reg                     res_reload_ff,
	output reg                     res_write_target_ff,
	output reg                     res_base_update_ff,
	output reg                     res_prefetch_ff,
	output reg                     res_set_deferred_bit_ff,
	output reg                     res_write_float_deferred_ff,
	output reg                     res_acquire_ff,
	output reg                     ev_done_ff,
	output reg  [`SAT_IDX_W:0]     occupancy_ff
);
	// ======================================================================
	// entry storage
	// ======================================================================
	reg [`SAT_ENTRIES-1:0] valid_ff;
	reg [`SAT_TAG_W-1:0]   tag_ff  [0:`SAT_ENTRIES-1];
	reg [`SAT_PA_W-1:0]    addr_ff [0:`SAT_ENTRIES-1];
	reg [`SAT_SIZE_W-1:0]  size_ff [0:`SAT_ENTRIES-1];
	reg [`SAT_IDX_W-1:0]   victim_ff;
	reg                    legacy_ff;

	wire [`SAT_TAG_W-1:0]   cur_tag;
	wire [`SAT_ENTRIES-1:0] tag_hit;
	wire [`SAT_ENTRIES-1:0] ev_ovl;
	wire [`SAT_ENTRIES-1:0] fld_same;

	sat_tag_gen u_tag (
		.reg_num     (op_reg_num),
		.reg_fr      (op_reg_fr),
		.stack_epoch (op_stack_epoch),
		.reg_tag     (cur_tag)
	);

	// ======================================================================
	// op and event decode
	// ======================================================================
	// ops in legacy mode see an empty table and leave it alone
	wire op_live    = op_valid & ~legacy_mode;
	wire is_adv     = (op_code == `SAT_OP_ADV);
	wire is_spec    = (op_code == `SAT_OP_SPEC_ADV);
	wire is_ld_nc   = (op_code == `SAT_OP_CHKLD_NC);
	wire is_ld_clr  = (op_code == `SAT_OP_CHKLD_CLR);
	wire is_acquire_load  = (op_code == `SAT_OP_CHKLD_ACQ);
	wire is_chk_clr = (op_code == `SAT_OP_CHKA_CLR);
	wire is_chk_nc  = (op_code == `SAT_OP_CHKA_NC);
	wire is_inv_all = (op_code == `SAT_OP_INV_ALL);
	wire is_inv_one = (op_code == `SAT_OP_INV_ONE);
	wire any_adv    = is_adv | is_spec;
	wire any_ld_chk = is_ld_nc | is_ld_clr | is_acquire_load;
	wire any_chk_a  = is_chk_clr | is_chk_nc;
	// a deferred token leaves no entry, so a later check always misses
	wire deferring  = is_spec & op_deferred;

	// spill stores are never looked at by the table
	wire ev_live = ev_valid & (ev_kind != `SAT_EV_SPILL);
	wire ev_page = (ev_kind == `SAT_EV_PURGE);
	// legacy entry throws everything away on the first legacy cycle
	wire legacy_enter = legacy_mode & ~legacy_ff;

	// ======================================================================
	// per entry lookup by tag and by address
	// ======================================================================
	genvar g;
	generate
		for (g = 0; g < `SAT_ENTRIES; g = g + 1) begin : g_look
			assign tag_hit[g] = valid_ff[g] & (tag_ff[g] == cur_tag);
			assign fld_same[g] = (addr_ff[g] == op_paddr) &
				(size_ff[g] == op_size);
			sat_overlap u_ovl (
				.ent_addr (addr_ff[g]),
				.ent_size (size_ff[g]),
				.ev_addr  (ev_paddr),
				.ev_page  (ev_page),
				.overlap  (ev_ovl[g])
			);
		end
	endgenerate

	// tags are unique, so at most one entry hits; a present tag always hits
	// outside legacy mode, since spurious misses would only cost the program recovery time
	wire hit      = op_live & (|tag_hit);
	// mismatch only matters for the fault option: the no-clear rewrite
	// below already replaces stale fields
	wire mismatch = hit & ~(|(tag_hit & fld_same));

	// ======================================================================
	// slot choice for allocation
	// ======================================================================
	// a hit reuses its own slot, so one tag never holds two entries
	reg [`SAT_IDX_W-1:0] free_idx;
	reg                  free_any;
	reg [`SAT_IDX_W-1:0] hit_idx;
	integer k;
	always @* begin
		free_idx = {`SAT_IDX_W{1'b0}};
		free_any = 1'b0;
		hit_idx  = {`SAT_IDX_W{1'b0}};
		for (k = `SAT_ENTRIES - 1; k >= 0; k = k - 1) begin
			if (!valid_ff[k]) begin
				free_idx = k[`SAT_IDX_W-1:0];
				free_any = 1'b1;
			end
			if (tag_hit[k]) begin
				hit_idx = k[`SAT_IDX_W-1:0];
			end
		end
	end

	// no-clear check load rewrites from its own fields only, on hit or
	// miss, so it is a kill of the tag plus a fresh allocation
	wire alloc = op_live & ((any_adv & ~deferring) | is_ld_nc);
	// a same-cycle memory event could hit the new entry; dropping the
	// allocation is the cheap safe answer
	wire alloc_ok = alloc & ~ev_live;
	wire [`SAT_IDX_W-1:0] alloc_idx = hit ? hit_idx :
		(free_any ? free_idx : victim_ff);

	// ======================================================================
	// explicit and implicit removal
	// ======================================================================
	// entries removed by tag this cycle; a failing clearing check finds
	// nothing to remove, so misses need no case of their own
	wire kill_tag = op_live & (any_adv | is_ld_nc | is_ld_clr | is_acquire_load |
		is_chk_clr | is_inv_one);
	wire kill_all = legacy_enter | (op_live & is_inv_all);

	// ======================================================================
	// entry state update
	// ======================================================================
	generate
		for (g = 0; g < `SAT_ENTRIES; g = g + 1) begin : g_ent
			wire take = alloc_ok &
				({{(32-`SAT_IDX_W){1'b0}}, alloc_idx} == g);
			wire drop = kill_all | (kill_tag & tag_hit[g]) |
				(ev_live & ev_ovl[g]);
			always @(posedge mclk) begin
				if (srst) begin
					valid_ff[g] <= 1'b0;
					tag_ff[g]   <= {`SAT_TAG_W{1'b0}};
					addr_ff[g]  <= {`SAT_PA_W{1'b0}};
					size_ff[g]  <= {`SAT_SIZE_W{1'b0}};
				end else if (take) begin
					valid_ff[g] <= 1'b1;
					tag_ff[g]   <= cur_tag;
					addr_ff[g]  <= op_paddr;
					size_ff[g]  <= op_size;
				end else if (drop) begin
					valid_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ======================================================================
	// occupancy and replacement state
	// ======================================================================
	// occupancy follows the table one cycle late, a registered count of valid_ff
	reg [`SAT_IDX_W:0] nxt_occupancy;
	integer m;
	always @* begin
		nxt_occupancy = {(`SAT_IDX_W+1){1'b0}};
		for (m = 0; m < `SAT_ENTRIES; m = m + 1) begin
			nxt_occupancy = nxt_occupancy +
				{{`SAT_IDX_W{1'b0}}, valid_ff[m]};
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			victim_ff    <= {`SAT_IDX_W{1'b0}};
			legacy_ff    <= 1'b0;
			occupancy_ff <= {(`SAT_IDX_W+1){1'b0}};
		end else begin
			legacy_ff    <= legacy_mode;
			occupancy_ff <= nxt_occupancy;
			// round-robin victim only moves when it was actually used
			if (alloc_ok && !hit && !free_any) begin
				victim_ff <= victim_ff + {{(`SAT_IDX_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ======================================================================
	// results to the pipeline, one cycle after the op
	// ======================================================================
	reg nxt_fall;
	reg nxt_branch;
	reg nxt_fault;
	reg nxt_reload;
	reg nxt_wr_tgt;
	reg nxt_base;
	reg nxt_pref;
	reg nxt_def_bit;
	reg nxt_def_flt;
	reg nxt_acq;
	always @* begin
		nxt_fall   = 1'b0;
		nxt_branch = 1'b0;
		nxt_fault  = 1'b0;
		nxt_reload = 1'b0;
		nxt_wr_tgt = 1'b0;
		nxt_base    = 1'b0;
		nxt_pref    = 1'b0;
		nxt_def_bit = 1'b0;
		nxt_def_flt = 1'b0;
		nxt_acq     = 1'b0;
		if (op_valid && any_chk_a) begin
			if (hit) begin
				nxt_fall = 1'b1;
			end else if (FAIL_AS_FAULT != 0) begin
				nxt_fault = 1'b1;
			end else begin
				nxt_branch = 1'b1;
			end
		end
		if (op_valid && any_ld_chk) begin
			nxt_acq = is_acquire_load;
			if (!hit || HIT_RELOAD != 0) begin
				// a real reload never hides its faults
				nxt_reload = 1'b1;
				nxt_wr_tgt = 1'b1;
				nxt_fault  = op_fault_pending;
			end else begin
				nxt_fault = op_fault_pending &
					(HIT_IGNORE_FAULTS == 0);
			end
			if (mismatch && MISMATCH_FAULT != 0) begin
				nxt_fault = 1'b1;
			end
		end
		if (op_valid && any_adv) begin
			nxt_wr_tgt = ~deferring;
			nxt_fault  = 1'b0;
			nxt_base    = op_base_upd;
			nxt_pref    = op_prefetch;
			nxt_def_bit = deferring & ~op_reg_fr;
			nxt_def_flt = deferring & op_reg_fr;
		end
	end

	// ======================================================================
	// result registers
	// ======================================================================
	always @(posedge mclk) begin
		if (srst) begin
			res_valid_ff                <= 1'b0;
			res_fall_through_ff         <= 1'b0;
			res_branch_ff               <= 1'b0;
			res_fault_ff                <= 1'b0;
			res_reload_ff               <= 1'b0;
			res_write_target_ff         <= 1'b0;
			res_base_update_ff          <= 1'b0;
			res_prefetch_ff             <= 1'b0;
			res_set_deferred_bit_ff     <= 1'b0;
			res_write_float_deferred_ff <= 1'b0;
			res_acquire_ff              <= 1'b0;
			ev_done_ff                  <= 1'b0;
		end else begin
			res_valid_ff        <= op_valid;
			res_fall_through_ff <= nxt_fall;
			res_branch_ff       <= nxt_branch;
			res_fault_ff        <= nxt_fault;
			res_reload_ff       <= nxt_reload;
			res_write_target_ff <= nxt_wr_tgt;
			res_base_update_ff  <= nxt_base;
			res_prefetch_ff     <= nxt_pref;
			res_set_deferred_bit_ff     <= nxt_def_bit;
			res_write_float_deferred_ff <= nxt_def_flt;
			res_acquire_ff      <= nxt_acq;
			// removal is already in the table when this acknowledges,
			// so the memory side may then make the event visible
			ev_done_ff          <= ev_valid;
		end
	end
endmodule // sat_table

// File: testbench/sat_pipe_model.sv
// pipeline and coherent-memory driver facing the speculation table
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_pipe_model (
	input wire mclk,
	output reg op_valid,
	output reg [`SAT_OP_W-1:0] op_code,
	output reg [`SAT_REG_W-1:0] op_reg_num,
	output reg op_reg_fr,
	output reg [`SAT_EPOCH_W-1:0] op_stack_epoch,
	output reg [`SAT_PA_W-1:0] op_paddr,
	output reg [`SAT_SIZE_W-1:0] op_size,
	output reg op_deferred,
	output reg op_base_upd,
	output reg op_prefetch,
	output reg op_fault_pending,
	output reg ev_valid,
	output reg [`SAT_EV_W-1:0] ev_kind,
	output reg [`SAT_PA_W-1:0] ev_paddr
);
	initial begin
		{op_valid, op_code, op_reg_num, op_reg_fr, op_stack_epoch} = 15'h0;
		{op_paddr, op_size, op_deferred, op_base_upd} = 39'h0;
		{op_prefetch, op_fault_pending, ev_valid} = 3'h0;
		{ev_kind, ev_paddr} = 35'h0;
	end
	// ==========================================
	// one op per call; valid drops a full cycle before it can rise again
	task op(input [3:0] c, input [9:0] t, input [31:0] a,
		input [4:0] s, input [3:0] f);
		@(posedge mclk);
		#1;
		{op_code, op_stack_epoch, op_reg_fr, op_reg_num} = {c, t};
		{op_paddr, op_size} = {a, s};
		{op_deferred, op_fault_pending, op_prefetch, op_base_upd} = f;
		op_valid = 1'b1;
		@(posedge mclk);
		#1;
		op_valid = 1'b0;
		// the released address lines must not keep a usable copy of the last access
		op_paddr = ~op_paddr;
	endtask
	task ev(input [2:0] k, input [31:0] a);
		@(posedge mclk);
		#1;
		{ev_kind, ev_paddr} = {k, a};
		ev_valid = 1'b1;
		@(posedge mclk);
		#1;
		ev_valid = 1'b0;
		ev_paddr = ~ev_paddr;
	endtask
endmodule // sat_pipe_model

// File: testbench/sat_table_sva.sv
// assertion checker for the speculation address table
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_table_sva (
	input wire mclk,
	input wire srst,
	input wire legacy_mode,
	input wire op_valid,
	input wire [`SAT_OP_W-1:0] op_code,
	input wire op_reg_fr,
	input wire op_deferred,
	input wire op_fault_pending,
	input wire ev_valid,
	input wire [`SAT_EV_W-1:0] ev_kind,
	input wire res_valid_ff,
	input wire res_fall_through_ff,
	input wire res_branch_ff,
	input wire res_fault_ff,
	input wire res_reload_ff,
	input wire res_write_target_ff,
	input wire res_set_deferred_bit_ff,
	input wire res_write_float_deferred_ff,
	input wire res_acquire_ff,
	input wire ev_done_ff,
	input wire [`SAT_IDX_W:0] occupancy_ff
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// ==========================================
	// assertions
	op_answer_a: assert property (op_valid |=> res_valid_ff)
		else $error("op gave no result");
	event_answer_a: assert property (ev_valid |=> ev_done_ff)
		else $error("event gave no done pulse");
	check_outcome_a: assert property (
		op_valid && (op_code == `SAT_OP_CHKA_CLR ||
		op_code == `SAT_OP_CHKA_NC) |=>
		res_fall_through_ff ^ res_branch_ff)
		else $error("check outcome not exactly one");
	acquire_cause_a: assert property (
		res_acquire_ff |->
		$past(op_valid) && $past(op_code) == `SAT_OP_CHKLD_ACQ)
		else $error("acquire without ordered check load");
	deferred_out_a: assert property (
		op_valid && !legacy_mode && op_code == `SAT_OP_SPEC_ADV &&
		op_deferred |=> !res_write_target_ff &&
		res_write_float_deferred_ff == $past(op_reg_fr) &&
		res_set_deferred_bit_ff == !$past(op_reg_fr))
		else $error("deferred load outputs wrong");
	clear_all_a: assert property (
		op_valid && op_code == `SAT_OP_INV_ALL |->
		##2 occupancy_ff == 0)
		else $error("table not empty after invalidate all");
	// a legacy entry in the same cycle may empty the table on its own
	spill_keep_a: assert property (
		ev_valid && ev_kind == `SAT_EV_SPILL && !op_valid &&
		!legacy_mode |-> ##2 $stable(occupancy_ff))
		else $error("spill changed the table");
	legacy_miss_a: assert property (
		op_valid && legacy_mode && (op_code == `SAT_OP_CHKA_CLR ||
		op_code == `SAT_OP_CHKA_NC) |=> res_branch_ff)
		else $error("check hit while legacy");
	reload_fault_a: assert property (
		res_reload_ff |->
		res_write_target_ff && res_fault_ff == $past(op_fault_pending))
		else $error("reload without write or fault");
	hit_fault_a: assert property (res_fault_ff |-> res_reload_ff)
		else $error("fault raised on a kept target");
	cover property (op_valid && op_code == `SAT_OP_CHKA_NC ##1
		res_fall_through_ff);
	cover property (res_reload_ff && res_fault_ff);
	cover property (ev_done_ff ##1 occupancy_ff < $past(occupancy_ff));
endmodule // sat_table_sva
bind sat_table sat_table_sva sat_table_sva_inst (
	.mclk                        (mclk),
	.srst                        (srst),
	.legacy_mode                 (legacy_mode),
	.op_valid                    (op_valid),
	.op_code                     (op_code),
	.op_reg_fr                   (op_reg_fr),
	.op_deferred                 (op_deferred),
	.op_fault_pending            (op_fault_pending),
	.ev_valid                    (ev_valid),
	.ev_kind                     (ev_kind),
	.res_valid_ff                (res_valid_ff),
	.res_fall_through_ff         (res_fall_through_ff),
	.res_branch_ff               (res_branch_ff),
	.res_fault_ff                (res_fault_ff),
	.res_reload_ff               (res_reload_ff),
	.res_write_target_ff         (res_write_target_ff),
	.res_set_deferred_bit_ff     (res_set_deferred_bit_ff),
	.res_write_float_deferred_ff (res_write_float_deferred_ff),
	.res_acquire_ff              (res_acquire_ff),
	.ev_done_ff                  (ev_done_ff),
	.occupancy_ff                (occupancy_ff)
);

// File: testbench/sat_table_tb_top.sv
// self-checking bench for the speculation address table
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_table_tb_top;
	reg mclk, srst, legacy_mode, lg;
	wire op_valid, op_reg_fr, op_deferred, op_base_upd, op_prefetch;
	wire op_fault_pending, ev_valid;
	wire [`SAT_OP_W-1:0] op_code;
	wire [`SAT_REG_W-1:0] op_reg_num;
	wire [`SAT_EPOCH_W-1:0] op_stack_epoch;
	wire [`SAT_PA_W-1:0] op_paddr, ev_paddr;
	wire [`SAT_SIZE_W-1:0] op_size;
	wire [`SAT_EV_W-1:0] ev_kind;
	wire res_valid_ff, res_fall_through_ff, res_branch_ff, res_fault_ff;
	wire res_reload_ff, res_write_target_ff, res_base_update_ff;
	wire res_prefetch_ff, res_set_deferred_bit_ff, res_acquire_ff;
	wire res_write_float_deferred_ff, ev_done_ff;
	wire [`SAT_IDX_W:0] occupancy_ff;
	integer err_count, n_compared, i, n;
	reg mv [0:1023];
	reg [31:0] ma [0:1023];
	reg [4:0] ms [0:1023];
	reg [9:0] t;
	reg [3:0] c;
	reg [31:0] a;
	reg [4:0] s;
	sat_table sat_table_inst (.*);
	sat_pipe_model sat_pipe_model_inst (.*);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ==========================================
	// compare and report
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wipe;
		for (i = 0; i < 1024; i = i + 1) mv[i] = 1'b0;
	endtask
	// occupancy trails the table by one cycle
	task occ;
		integer k, m;
		m = 0;
		for (k = 0; k < 1024; k = k + 1) m = m + mv[k];
		@(posedge mclk);
		#1;
		chk("occupancy", m, occupancy_ff);
	endtask
	// ==========================================
	// reference model of one op and one event
	task run_op(input [3:0] c, input [9:0] t, input [31:0] a,
		input [4:0] s, input [3:0] f);
		reg h, ld, ck, d;
		h = mv[t] & ~lg;
		ld = c >= 2 && c <= 4;
		ck = c == 5 || c == 6;
		d = c == 1 && f[3];
		sat_pipe_model_inst.op(c, t, a, s, f);
		chk("res_valid", 1'b1, res_valid_ff);
		chk("fall_through", ck & h, res_fall_through_ff);
		chk("branch", ck & ~h, res_branch_ff);
		chk("reload", ld & ~h, res_reload_ff);
		chk("fault", ld & ~h & f[2], res_fault_ff);
		chk("acquire", c == 4, res_acquire_ff);
		chk("write_target", (c < 2 & ~d) | (ld & ~h), res_write_target_ff);
		chk("deferred_bit", d & ~t[7], res_set_deferred_bit_ff);
		chk("float_deferred", d & t[7], res_write_float_deferred_ff);
		if (!d) begin
			chk("base_update", (c < 2) & f[0], res_base_update_ff);
			chk("prefetch", (c < 2) & f[1], res_prefetch_ff);
		end
		if (lg) n = n;
		else if (c == 7) wipe;
		else if (c < 3 && !d) {mv[t], ma[t], ms[t]} = {1'b1, a, s};
		else if (c != 6) mv[t] = 1'b0;
		occ;
	endtask
	task run_ev(input [2:0] k, input [31:0] a);
		integer j, sh;
		sh = k == `SAT_EV_PURGE ? 12 : 6;
		sat_pipe_model_inst.ev(k, a);
		chk("ev_done", 1'b1, ev_done_ff);
		for (j = 0; j < 1024; j = j + 1)
			if (k != `SAT_EV_SPILL && (ma[j] >> sh == a >> sh || (ma[j] + ms[j] - 1) >> sh == a >> sh)) mv[j] = 1'b0;
		occ;
	endtask
	initial begin
		#500000;
		err_count = err_count + 1;
		print_verdict;
	end
	initial begin
		{err_count, n_compared, lg, srst, legacy_mode} = {32'h0, 32'h0, 3'h2};
		for (i = 0; i < 1024; i = i + 1) {mv[i], ma[i], ms[i]} = {1'b0, 32'h1000_0000, 5'h08};
		repeat (12) @(posedge mclk);
		#1;
		srst = 1'b0;
		void'($urandom(7));
		for (n = 0; n < 9; n = n + 1) run_op(n[3:0], 10'h005, 32'h0000_1000, 5'h08, 4'hF);
		for (n = 0; n < 400; n = n + 1) begin
			t = 10'($urandom) & 10'h181;
			c = 4'($urandom % 9);
			if ($urandom % 4 == 0) begin
				c = 4'($urandom % 6);
				a = ma[t] ^ (32'($urandom) & (c == `SAT_EV_PURGE ? 32'hFFF : 32'h7F));
				run_ev(c[2:0], a);
			end else begin
				// invalidate-all kept rare so the table stays populated
				if (c == 7 && $urandom % 4 != 0) c = 4'h6;
				a = 32'h1000_0000 + (32'($urandom) & 32'h1FF8);
				s = 5'h01 << ($urandom % 5);
				if (c > 1) {a, s} = {ma[t], ms[t]};
				run_op(c, t, a, s, 4'($urandom));
			end
		end
		// the program purges the table after a mapping change
		run_op(4'h7, 10'h000, 32'h0000_2000, 5'h04, 4'h0);
		run_op(4'h0, 10'h001, 32'h0000_2000, 5'h04, 4'h0);
		@(posedge mclk);
		#1;
		{legacy_mode, lg} = 2'h3;
		wipe;
		run_op(4'h6, 10'h001, 32'h0000_2000, 5'h04, 4'h0);
		{legacy_mode, lg} = 2'h0;
		run_op(4'h6, 10'h001, 32'h0000_2000, 5'h04, 4'h0);
		print_verdict;
	end
endmodule // sat_table_tb_top
